// ===== logic/xte_exec.sv
// Executor for port direction load and two exclusive-OR instructions.
// Assumes an APB master writes instruction words and inspects state.
// Function
// RULE1: Direction-load opcode copies working register into direction register 5, 6 or 7.
// RULE2: Literal exclusive-OR opcode XORs working register with 8-bit literal.
// RULE3: Literal result goes to working register; only zero flag changes.
// RULE4: Register exclusive-OR XORs working register with file register 0..31; zero flag only.
// RULE5: Destination bit 0 writes working register, 1 writes the file register.
// RULE6: Zero flag set on zero result; each instruction completes in one cycle.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module xte_exec #(
	parameter int NREG = xte_pkg::NUM_FREG
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [xte_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic                     pslverr,
	output logic [31:0]              prdata,
	output logic [xte_pkg::DATA_W-1:0] port_dir_a,
	output logic [xte_pkg::DATA_W-1:0] port_dir_b,
	output logic [xte_pkg::DATA_W-1:0] port_dir_c,
	output logic                     zero_flag,
	output logic                     exec_done
);
	import xte_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0]              w;
		logic [NUM_DIR-1:0][DATA_W-1:0] dir;
		logic [NREG-1:0][DATA_W-1:0]    freg;
		logic                           z;
		logic                           done;
		logic [31:0]                    rdata;
	} xte_state_t;

	typedef enum logic [3:0] {
		OP_NONE = 4'h1,
		OP_DIR  = 4'h2,
		OP_LIT  = 4'h4,
		OP_REG  = 4'h8
	} xte_op_t;

	xte_state_t        st_reg;
	xte_state_t        st_next;
	xte_apb_req_t      req;
	xte_dec_t          dec;
	logic [INSTR_W-1:0] instr;
	logic              wr_en;
	logic              rd_en;
	logic              addr_ok;
	logic              is_freg;
	logic [FADDR_W-1:0] fidx;
	logic [DATA_W-1:0] result;
	logic [DATA_W-1:0] operand;
	logic [1:0]        dir_idx;

	logic               acc_phase;
	logic               setup_phase;
	logic               hit_instr;
	logic               hit_wreg;
	logic               hit_status;
	logic [NUM_DIR-1:0] hit_dir;
	logic               freg_in_range;
	logic               instr_wr;
	logic               wreg_wr;
	logic               freg_wr;

	logic [NREG-1:0]    freg_we;
	logic [NREG-1:0]    freg_rd_sel;
	logic [NREG-1:0]    freg_op_sel;
	logic [DATA_W-1:0]  freg_rd_val;
	logic [DATA_W-1:0]  dir_rd_val;
	logic [31:0]        rd_word;

	xte_op_t            op_kind;
	logic [DATA_W-1:0]  freg_operand;
	logic [DATA_W-1:0]  w_exec;
	logic [DATA_W-1:0]  freg_exec;
	logic               w_exec_we;
	logic               freg_exec_we;
	logic               dir_exec_we;
	logic [NUM_DIR-1:0] dir_we;
	logic               z_exec_we;
	logic               z_result;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
		pwdata: pwdata};

	// No wait states; every access ends in its first access cycle
	assign acc_phase   = req.psel && req.penable;
	assign setup_phase = req.psel && !req.penable;
	assign wr_en   = acc_phase && req.pwrite;
	assign rd_en   = setup_phase && !req.pwrite;
	assign instr   = req.pwdata[INSTR_W-1:0];
	assign is_freg = ((req.paddr & A_FREG_MASK) == A_FREG_BASE);
	assign fidx    = req.paddr[FADDR_W+WORD_LSB-1:WORD_LSB];

	// Exact-match decode; misaligned words hit nothing and are refused
	assign hit_instr     = (req.paddr == A_INSTR);
	assign hit_wreg      = (req.paddr == A_WREG);
	assign hit_status    = (req.paddr == A_STATUS);
	assign hit_dir[0]    = (req.paddr == A_DIR0);
	assign hit_dir[1]    = (req.paddr == A_DIR1);
	assign hit_dir[2]    = (req.paddr == A_DIR2);

	assign freg_in_range = is_freg && (req.paddr[WORD_LSB-1:0] == ALIGN_OK)
		&& (32'(fidx) < NREG);
	assign addr_ok       = hit_instr || hit_wreg || hit_status || (|hit_dir)
		|| freg_in_range;

	assign instr_wr = wr_en && hit_instr;
	assign wreg_wr  = wr_en && hit_wreg;
	assign freg_wr  = wr_en && freg_in_range;

	// One write strobe and two selects per file register
	for (genvar g = 0; g < NREG; g++) begin : g_freg
		assign freg_we[g]     = freg_wr && (fidx == FADDR_W'(g));
		assign freg_rd_sel[g] = freg_in_range && (fidx == FADDR_W'(g));
		assign freg_op_sel[g] = (dec.faddr == FADDR_W'(g));
	end

	always_comb begin
		freg_rd_val = '0;
		for (int i = 0; i < NREG; i++) begin
			if (freg_rd_sel[i]) begin
				freg_rd_val = st_reg.freg[i];
			end
		end
	end

	always_comb begin
		dir_rd_val = '0;
		for (int i = 0; i < NUM_DIR; i++) begin
			if (hit_dir[i]) begin
				dir_rd_val = st_reg.dir[i];
			end
		end
	end

	xte_decode xte_decode_i (
		.instr (instr),
		.dec   (dec)
	);

	// Register operand read and both results formed in the same cycle
	always_comb begin
		freg_operand = '0;
		for (int i = 0; i < NREG; i++) begin
			if (freg_op_sel[i]) begin
				freg_operand = st_reg.freg[i];
			end
		end
	end
	assign operand = dec.lit_xor ? dec.literal : freg_operand;            // see RULE4
	assign result  = st_reg.w ^ operand;                                  // see RULE2
	assign dir_idx = 2'(dec.dir_sel - DIR_SEL_MIN);

	// Zero detect kept bitwise so the flag follows the data width
	always_comb begin
		z_result = 1'b1;
		for (int b = 0; b < DATA_W; b++) begin
			if (result[b]) begin
				z_result = 1'b0;                                      // see RULE6
			end
		end
	end

	always_comb begin
		op_kind = OP_NONE;
		if (instr_wr && dec.dir_load) begin
			op_kind = OP_DIR;                                         // see RULE1
		end else if (instr_wr && dec.lit_xor) begin
			op_kind = OP_LIT;                                         // see RULE2
		end else if (instr_wr && dec.reg_xor) begin
			op_kind = OP_REG;                                         // see RULE4
		end
	end

	// Each instruction resolves to write enables for this one cycle
	always_comb begin
		w_exec       = st_reg.w;
		freg_exec    = freg_operand;
		w_exec_we    = 1'b0;
		freg_exec_we = 1'b0;
		dir_exec_we  = 1'b0;
		z_exec_we    = 1'b0;
		unique case (op_kind)
			OP_DIR: begin
				dir_exec_we  = 1'b1;                                  // see RULE1
			end
			OP_LIT: begin
				w_exec       = result;                                // see RULE3
				w_exec_we    = 1'b1;                                  // see RULE3
				z_exec_we    = 1'b1;                                  // see RULE3
			end
			OP_REG: begin
				w_exec       = result;
				freg_exec    = result;
				w_exec_we    = !dec.to_freg;                          // see RULE5
				freg_exec_we = dec.to_freg;                           // see RULE5
				z_exec_we    = 1'b1;                                  // see RULE4
			end
			OP_NONE: begin
				dir_exec_we  = 1'b0;
			end
		endcase
	end

	// One load strobe per direction register
	for (genvar d = 0; d < NUM_DIR; d++) begin : g_dir
		assign dir_we[d] = dir_exec_we && (dir_idx == 2'(d));         // see RULE1
	end

	// Read word formed in the setup cycle; upper bits read as zero
	always_comb begin
		rd_word = RDATA_RESET;
		if (hit_wreg) begin
			rd_word[DATA_W-1:0] = st_reg.w;
		end else if (hit_status) begin
			rd_word[ZERO_BIT] = st_reg.z;
		end else if (|hit_dir) begin
			rd_word[DATA_W-1:0] = dir_rd_val;
		end else if (freg_in_range) begin
			rd_word[DATA_W-1:0] = freg_rd_val;
		end
	end

	always_comb begin
		st_next      = st_reg;
		// Single write executes the whole instruction
		st_next.done = instr_wr;                                    // see RULE6

		// Working register: instruction result or direct bus write
		if (w_exec_we) begin
			st_next.w = w_exec;                                     // see RULE3
		end else if (wreg_wr) begin
			st_next.w = req.pwdata[DATA_W-1:0];
		end

		if (z_exec_we) begin
			st_next.z = z_result;                                   // see RULE6
		end

		for (int d = 0; d < NUM_DIR; d++) begin
			if (dir_we[d]) begin
				st_next.dir[d] = st_reg.w;                          // see RULE1
			end
		end

		// File registers: instruction destination or direct bus write
		for (int i = 0; i < NREG; i++) begin
			if (freg_exec_we && freg_op_sel[i]) begin
				st_next.freg[i] = freg_exec;                        // see RULE5
			end else if (freg_we[i]) begin
				st_next.freg[i] = req.pwdata[DATA_W-1:0];
			end
		end

		if (rd_en) begin
			st_next.rdata = rd_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.w     <= W_RESET;
			for (int d = 0; d < NUM_DIR; d++) begin
				st_reg.dir[d] <= DIR_RESET;
			end
			for (int i = 0; i < NREG; i++) begin
				st_reg.freg[i] <= FREG_RESET;
			end
			st_reg.z     <= 1'b0;
			st_reg.done  <= 1'b0;
			st_reg.rdata <= RDATA_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// Zero wait states: every access phase completes at once
	assign pready     = 1'b1;
	assign pslverr    = acc_phase && !addr_ok;
	assign prdata     = st_reg.rdata;
	assign port_dir_a = st_reg.dir[0];
	assign port_dir_b = st_reg.dir[1];
	assign port_dir_c = st_reg.dir[2];
	assign zero_flag  = st_reg.z;
	assign exec_done  = st_reg.done;
endmodule : xte_exec

// ===== logic/xte_pkg.sv
// Package for the exclusive-OR and port direction load executor.
// Assumes a 12-bit instruction word and an 8-bit data path.
package xte_pkg;
	localparam int          DATA_W       = 8;
	localparam int          INSTR_W      = 12;
	localparam int          FADDR_W      = 5;
	localparam int          NUM_FREG     = 32;
	localparam int          NUM_DIR      = 3;
	localparam int          DIR_SEL_W    = 3;
	localparam logic [11:0] OPC_DIR_MASK = 12'hff8;
	localparam logic [11:0] OPC_DIR_VAL  = 12'h000;
	localparam logic [2:0]  DIR_SEL_MIN  = 3'h5;
	localparam logic [2:0]  DIR_SEL_MAX  = 3'h7;
	localparam logic [11:0] OPC_LIT_MASK = 12'hf00;
	localparam logic [11:0] OPC_LIT_VAL  = 12'hf00;
	localparam logic [11:0] OPC_REG_MASK = 12'hfc0;
	localparam logic [11:0] OPC_REG_VAL  = 12'h180;
	localparam int          DEST_BIT     = 5;
	localparam logic [7:0]  W_RESET      = 8'h00;
	localparam logic [7:0]  DIR_RESET    = 8'hff;
	localparam logic [7:0]  FREG_RESET   = 8'h00;
	localparam int          APB_AW       = 12;
	// Register byte addresses
	localparam logic [11:0] A_INSTR      = 12'h000;
	localparam logic [11:0] A_WREG       = 12'h004;
	localparam logic [11:0] A_STATUS     = 12'h008;
	localparam logic [11:0] A_DIR0       = 12'h00c;
	localparam logic [11:0] A_FREG_BASE  = 12'h080;
	localparam logic [11:0] A_FREG_MASK  = 12'hf80;
	localparam logic [11:0] A_DIR1       = 12'h010;
	localparam logic [11:0] A_DIR2       = 12'h014;
	localparam int          WORD_LSB     = 2;
	localparam logic [1:0]  ALIGN_OK     = 2'h0;
	localparam int          ZERO_BIT     = 0;
	localparam logic [31:0] RDATA_RESET  = 32'h0;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [APB_AW-1:0] paddr;
		logic [31:0]       pwdata;
	} xte_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} xte_apb_rsp_t;

	typedef struct packed {
		logic                 dir_load;
		logic                 lit_xor;
		logic                 reg_xor;
		logic [DIR_SEL_W-1:0] dir_sel;
		logic [DATA_W-1:0]    literal;
		logic [FADDR_W-1:0]   faddr;
		logic                 to_freg;
	} xte_dec_t;
endpackage : xte_pkg

// ===== logic/xte_decode.sv
// Opcode decoder for the three executed instructions.
// Assumes a 12-bit instruction word; purely combinational.
`timescale 1ns/1ps
module xte_decode (
	input  wire logic [xte_pkg::INSTR_W-1:0] instr,
	output xte_pkg::xte_dec_t                dec
);
	import xte_pkg::*;

	logic dir_hit;

	// Reserved selects 0..4 decode as no operation
	assign dir_hit = ((instr & OPC_DIR_MASK) == OPC_DIR_VAL)
		&& (instr[DIR_SEL_W-1:0] >= DIR_SEL_MIN)
		&& (instr[DIR_SEL_W-1:0] <= DIR_SEL_MAX);          // see RULE1

	always_comb begin
		dec.dir_load = dir_hit;                                  // see RULE1
		dec.lit_xor  = ((instr & OPC_LIT_MASK) == OPC_LIT_VAL);  // see RULE2
		dec.reg_xor  = ((instr & OPC_REG_MASK) == OPC_REG_VAL);  // see RULE4
		dec.dir_sel  = instr[DIR_SEL_W-1:0];
		dec.literal  = instr[DATA_W-1:0];
		dec.faddr    = instr[FADDR_W-1:0];
		dec.to_freg  = instr[DEST_BIT];                          // see RULE5
	end
endmodule : xte_decode

// ===== testbench/xte_exec_props.sv
// Port checker for the exclusive-OR and direction load executor.
// Assumes it is bound to xte_exec and sees only its ports.
`timescale 1ns/1ps
module xte_exec_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  port_dir_a,
	input wire logic [7:0]  port_dir_b,
	input wire logic [7:0]  port_dir_c,
	input wire logic        zero_flag,
	input wire logic        exec_done
);
	import xte_pkg::*;
	wire logic [11:0] op = pwdata[11:0];
	wire logic        wr = psel && penable && pwrite && (paddr == A_INSTR);
	wire logic        xo = ((op & OPC_LIT_MASK) == OPC_LIT_VAL) || ((op & OPC_REG_MASK) == OPC_REG_VAL);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_always: assert property (psel && penable |-> pready) else $error("no ready");
	a_done_after_write: assert property (wr |=> exec_done) else $error("no done");
	a_done_has_cause: assert property (exec_done |-> $past(wr)) else $error("stray done");
	a_dir_a_cause: assert property ($changed(port_dir_a) |-> $past(wr && op == 12'h005))
		else $error("dir a moved");
	a_dir_b_cause: assert property ($changed(port_dir_b) |-> $past(wr && op == 12'h006))
		else $error("dir b moved");
	a_dir_c_cause: assert property ($changed(port_dir_c) |-> $past(wr && op == 12'h007))
		else $error("dir c moved");
	a_zero_cause: assert property ($changed(zero_flag) |-> $past(wr && xo))
		else $error("zero moved");
	a_dir_keeps_zero: assert property (wr && (op & OPC_DIR_MASK) == OPC_DIR_VAL |=> $stable(zero_flag))
		else $error("zero touched");
	a_instr_no_err: assert property (wr |-> !pslverr) else $error("instr refused");
endmodule : xte_exec_props

bind xte_exec xte_exec_props xte_exec_props_i (.*);

// ===== testbench/test_xor_and_tristate_load_exec.sv
// Self-checking bench for the exclusive-OR and direction load executor.
// Assumes a zero-wait APB slave with the register map of the package.
`timescale 1ns/1ps
module test_xor_and_tristate_load_exec;
	import xte_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        pready, pslverr, zero_flag, exec_done, err;
	logic [31:0] prdata, rd;
	logic [7:0]  dir_a, dir_b, dir_c;
	int          mismatches = 0;
	int          n_checks = 0;
	always #20 pclk = ~pclk;
	xte_exec xte_exec_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .port_dir_a(dir_a), .port_dir_b(dir_b), .port_dir_c(dir_c),
		.zero_flag(zero_flag), .exec_done(exec_done));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Request held until pready is seen; data and error taken at that edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic ex(input logic [11:0] o);
		xfer(1'b1, A_INSTR, {20'h0, o});
		check(err, 1'b0);
		#1;
		check(exec_done, 1'b1);
	endtask : ex
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		check(rd, e);
	endtask : rdchk
	task automatic t_literal;
		xfer(1'b1, A_WREG, 32'hb5);
		ex(12'hfaf);
		rdchk(A_WREG, 32'h1a);
		check(zero_flag, 1'b0);
		ex(12'hf1a);
		rdchk(A_WREG, 32'h0);
		rdchk(A_STATUS, 32'h1);
	endtask : t_literal
	task automatic t_regxor;
		xfer(1'b1, A_WREG, 32'hb5);
		xfer(1'b1, A_FREG_BASE + 12'h07c, 32'haf);
		ex(12'h1bf);
		rdchk(A_FREG_BASE + 12'h07c, 32'h1a);
		rdchk(A_WREG, 32'hb5);
		check(zero_flag, 1'b0);
		ex(12'h19f);
		rdchk(A_WREG, 32'haf);
		ex(12'h1a0);
		rdchk(A_FREG_BASE, 32'haf);
		check(zero_flag, 1'b0);
		ex(12'h1a0);
		rdchk(A_FREG_BASE, 32'h0);
		check(zero_flag, 1'b1);
	endtask : t_regxor
	// Select 4 is invalid and must leave every direction register alone
	task automatic t_dir;
		for (int s = 4; s < 8; s++) begin
			xfer(1'b1, A_WREG, 32'(s * 17));
			ex({9'h0, 3'(s)});
		end
		check({dir_a, dir_b, dir_c}, 32'h556677);
		rdchk(A_DIR0 + 12'h008, 32'h77);
		check(zero_flag, 1'b1);
	endtask : t_dir
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check({dir_a, dir_b, dir_c, 7'h0, zero_flag}, 32'hffffff00);
		t_literal();
		t_regxor();
		t_dir();
		xfer(1'b0, 12'h006, 32'h0);
		check({err, rd[30:0]}, 32'h80000000);
		xfer(1'b1, A_FREG_BASE + 12'h001, 32'h5a);
		check(err, 1'b1);
		rdchk(A_FREG_BASE, 32'h0);
		summarize();
	end
	initial begin
		repeat (3000) @(posedge pclk);
		mismatches++;
		summarize();
	end
endmodule : test_xor_and_tristate_load_exec
